// [shared/pcd_pkg.sv]
// Constants and types shared by the pin change detector design.
package pcd_pkg;

	// =========================================================
	// Geometry.
	localparam int PIN_COUNT = 6;
	localparam int DATA_W    = 32;
	localparam int ADDR_W    = 8;

	// =========================================================
	// Register offsets, byte addresses.
	localparam logic [ADDR_W-1:0] OFS_RISE_EN = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FALL_EN = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h14;

	// =========================================================
	// Reset values.
	localparam logic [7:0] RESET_PIN_REG = 8'h00;
	localparam logic       RESET_BIT     = 1'b0;

	// =========================================================
	// Interrupt control field positions.
	localparam int CTRL_GIE_BIT = 7;
	localparam int CTRL_IE_BIT  = 3;
	localparam int CTRL_SUM_BIT = 0;

	// =========================================================
	// Bus slave states.
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,
		BUS_WRITE = 3'b010,
		BUS_READ  = 3'b100
	} pcd_bus_state_t;

endpackage

// [hw/pcd_edge_detect.sv]
// Per pin synchroniser and edge detector.
`timescale 1ns/100ps
module pcd_edge_detect #(
	parameter int WIDTH = pcd_pkg::PIN_COUNT
) (
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             rst,
	// Raw pins.
	input  wire logic [WIDTH-1:0] pin_in,
	// Edge pulses.
	output logic      [WIDTH-1:0] rise_pulse,
	output logic      [WIDTH-1:0] fall_pulse
);

	// =========================================================
	// Synchroniser and previous sample, one set per pin.
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					meta_reg[i] <= 1'b0;
					sync_reg[i] <= 1'b0;
					prev_reg[i] <= 1'b0;
				end else begin
					meta_reg[i] <= pin_in[i];
					sync_reg[i] <= meta_reg[i];
					prev_reg[i] <= sync_reg[i];
				end
			end

			assign rise_pulse[i] = sync_reg[i] & ~prev_reg[i];
			assign fall_pulse[i] = ~sync_reg[i] & prev_reg[i];
		end
	endgenerate

endmodule

// [hw/pcd_top.sv]
// Pin change detector with AHB-Lite register slave.
`timescale 1ns/100ps
module pcd_top #(
	parameter int PINS = pcd_pkg::PIN_COUNT
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Monitored port pins.
	input  wire logic [PINS-1:0] port_a_pin,
	// Core handshake.
	input  wire logic        core_sleep,
	output logic             core_irq_req,
	output logic             core_wake_req,
	output logic             global_irq_enable,
	// Interrupt.
	output logic             irq
);

	// =========================================================
	// Declarations.
	pcd_pkg::pcd_bus_state_t state_reg;
	pcd_pkg::pcd_bus_state_t state_next;

	logic [pcd_pkg::ADDR_W-1:0] addr_reg;
	logic                       hreadyout_reg;
	logic [31:0]                hrdata_reg;
	logic                       hresp_reg;

	logic [PINS-1:0] rise_en_reg;
	logic [PINS-1:0] fall_en_reg;
	logic [PINS-1:0] flags_reg;
	logic [PINS-1:0] flags_next;
	logic            ie_reg;
	logic            ie_next;
	logic            gie_reg;
	logic [PINS-1:0] status_reg;
	logic [PINS-1:0] status_next;
	logic [PINS-1:0] mask_reg;
	logic [PINS-1:0] mask_next;

	logic            irq_reg;
	logic            core_irq_reg;
	logic            wake_reg;

	logic [PINS-1:0] rise_pulse;
	logic [PINS-1:0] fall_pulse;
	logic [PINS-1:0] qual_edge;

	logic            accept;
	logic            wr_phase;
	logic            wr_rise;
	logic            wr_fall;
	logic            wr_flags;
	logic            wr_ctrl;
	logic            wr_status;
	logic            wr_mask;
	logic            summary;

	// =========================================================
	// Edge detection.
	pcd_edge_detect #(
		.WIDTH      (PINS)
	) u_edge (
		.clock      (clock),
		.rst        (rst),
		.pin_in     (port_a_pin),
		.rise_pulse (rise_pulse),
		.fall_pulse (fall_pulse)
	);

	assign qual_edge = (rise_pulse & rise_en_reg)
		| (fall_pulse & fall_en_reg);

	// Summary is OR of pin flags.
	assign summary = |flags_reg;

	// =========================================================
	// Bus slave.
	assign accept   = hsel & htrans[1] & hready;
	assign wr_phase = (state_reg == pcd_pkg::BUS_WRITE);
	assign wr_rise  = wr_phase & (addr_reg == pcd_pkg::OFS_RISE_EN);
	assign wr_fall  = wr_phase & (addr_reg == pcd_pkg::OFS_FALL_EN);
	assign wr_flags = wr_phase & (addr_reg == pcd_pkg::OFS_FLAGS);
	assign wr_ctrl  = wr_phase & (addr_reg == pcd_pkg::OFS_CTRL);
	assign wr_status = wr_phase & (addr_reg == pcd_pkg::OFS_STATUS);
	assign wr_mask  = wr_phase & (addr_reg == pcd_pkg::OFS_MASK);

	always_comb begin
		state_next = pcd_pkg::BUS_IDLE;
		case (state_reg)
			pcd_pkg::BUS_IDLE,
			pcd_pkg::BUS_WRITE: begin
				if (accept & hwrite) begin
					state_next = pcd_pkg::BUS_WRITE;
				end else if (accept) begin
					state_next = pcd_pkg::BUS_READ;
				end
			end
			pcd_pkg::BUS_READ: begin
				state_next = pcd_pkg::BUS_IDLE;
			end
			default: begin
				state_next = pcd_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= pcd_pkg::BUS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			addr_reg <= '0;
		end else if (accept) begin
			addr_reg <= haddr[pcd_pkg::ADDR_W-1:0];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end else begin
			hreadyout_reg <= (state_next != pcd_pkg::BUS_READ);
			hresp_reg     <= 1'b0;
		end
	end

	// Read data is loaded in the wait state, after any write.
	function automatic logic [31:0] pad(input logic [PINS-1:0] v);
		pad = {{(32 - PINS){1'b0}}, v};
	endfunction

	// Unused upper bits read as zero.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (state_reg == pcd_pkg::BUS_READ) begin
			case (addr_reg)
				pcd_pkg::OFS_RISE_EN: hrdata_reg <= pad(rise_en_reg);
				pcd_pkg::OFS_FALL_EN: hrdata_reg <= pad(fall_en_reg);
				pcd_pkg::OFS_FLAGS:   hrdata_reg <= pad(flags_reg);
				pcd_pkg::OFS_CTRL: begin
					hrdata_reg <= 32'h0000_0000;
					hrdata_reg[pcd_pkg::CTRL_GIE_BIT] <= gie_reg;
					hrdata_reg[pcd_pkg::CTRL_IE_BIT]  <= ie_reg;
					hrdata_reg[pcd_pkg::CTRL_SUM_BIT] <= summary;
				end
				pcd_pkg::OFS_STATUS:  hrdata_reg <= pad(status_reg);
				pcd_pkg::OFS_MASK:    hrdata_reg <= pad(mask_reg);
				default:              hrdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hresp     = hresp_reg;
	assign hrdata    = hrdata_reg;

	// =========================================================
	// Edge enable registers.
	// Enables reset to zero.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rise_en_reg <= pcd_pkg::RESET_PIN_REG[PINS-1:0];
		end else if (wr_rise) begin
			rise_en_reg <= hwdata[PINS-1:0];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fall_en_reg <= pcd_pkg::RESET_PIN_REG[PINS-1:0];
		end else if (wr_fall) begin
			fall_en_reg <= hwdata[PINS-1:0];
		end
	end

	// =========================================================
	// Pin change flags.
	// Hardware set wins over a write.
	// Flags set whatever the master enable.
	always_comb begin
		flags_next = flags_reg;
		// Software can only clear flags; a written one keeps the flag.
		if (wr_flags) begin
			flags_next = flags_reg & hwdata[PINS-1:0];
		end
		flags_next = flags_next | qual_edge;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flags_reg <= pcd_pkg::RESET_PIN_REG[PINS-1:0];
		end else begin
			flags_reg <= flags_next;
		end
	end

	// =========================================================
	// Interrupt control register.
	// Master and global enable bits.
	assign ie_next = wr_ctrl ? hwdata[pcd_pkg::CTRL_IE_BIT] : ie_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ie_reg  <= pcd_pkg::RESET_BIT;
			gie_reg <= pcd_pkg::RESET_BIT;
		end else begin
			ie_reg <= ie_next;
			if (wr_ctrl) begin
				gie_reg <= hwdata[pcd_pkg::CTRL_GIE_BIT];
			end
		end
	end

	// =========================================================
	// Core request and wake.
	// Request while summary and master set.
	// Wake only once the flag is stored.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			core_irq_reg <= 1'b0;
			wake_reg     <= 1'b0;
		end else begin
			core_irq_reg <= ie_next & (|flags_next);
			wake_reg     <= core_sleep & ie_next & (|flags_next);
		end
	end

	assign core_irq_req      = core_irq_reg;
	assign core_wake_req     = wake_reg;
	assign global_irq_enable = gie_reg;

	// =========================================================
	// Sticky event status, mask and interrupt line.
	always_comb begin
		status_next = status_reg;
		if (wr_status) begin
			status_next = status_reg & ~hwdata[PINS-1:0];
		end
		status_next = status_next | qual_edge;
	end

	assign mask_next = wr_mask ? hwdata[PINS-1:0] : mask_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			status_reg <= pcd_pkg::RESET_PIN_REG[PINS-1:0];
			mask_reg   <= pcd_pkg::RESET_PIN_REG[PINS-1:0];
			irq_reg    <= 1'b0;
		end else begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			irq_reg    <= |(status_next & mask_next);
		end
	end

	assign irq = irq_reg;

	// =========================================================
	// Assertions.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_rise_sets_flag: assert property (
		|(rise_pulse & rise_en_reg) |=>
		((flags_reg & $past(rise_pulse & rise_en_reg))
			== $past(rise_pulse & rise_en_reg)))
		else $error("Enabled rising edge did not set flag.");

	a_fall_sets_flag: assert property (
		|(fall_pulse & fall_en_reg) |=>
		((flags_reg & $past(fall_pulse & fall_en_reg))
			== $past(fall_pulse & fall_en_reg)))
		else $error("Enabled falling edge did not set flag.");

	a_no_stray_set: assert property (
		!wr_flags |=>
		((flags_reg & ~$past(flags_reg) & ~$past(qual_edge)) == '0))
		else $error("Flag set without an enabled edge.");

	a_write_no_set: assert property (
		wr_flags |=>
		((flags_reg & ~$past(flags_reg) & ~$past(qual_edge)) == '0))
		else $error("Software write set a change flag.");

	a_flag_sticky: assert property (
		!wr_flags ##1 1'b1 |->
		((flags_reg & $past(flags_reg)) == $past(flags_reg)))
		else $error("Flag cleared without a write.");

	a_upper_zero: assert property (
		(state_reg == pcd_pkg::BUS_READ)
		&& (addr_reg != pcd_pkg::OFS_CTRL) |=> hrdata[31:PINS] == '0)
		else $error("Unimplemented bits read as one.");

	a_ctrl_reserved: assert property (
		(state_reg == pcd_pkg::BUS_READ)
		&& (addr_reg == pcd_pkg::OFS_CTRL) |=>
		hrdata[31:8] == '0 && hrdata[6:4] == '0 && hrdata[2:1] == '0)
		else $error("Reserved control bits read as one.");

	a_wake_request: assert property (
		core_sleep && ie_reg && !wr_ctrl && |qual_edge |=> core_wake_req)
		else $error("Enabled edge in sleep gave no wake.");

	a_wake_flagged: assert property (
		core_wake_req |-> summary)
		else $error("Wake raised before flag recorded.");

	a_detect_masked: assert property (
		!ie_reg && !wr_ctrl && |qual_edge |=> summary && !core_irq_req)
		else $error("Detection stopped with master enable clear.");

	a_clear_race: assert property (
		wr_flags && |qual_edge |=>
		((flags_reg & $past(qual_edge)) == $past(qual_edge)))
		else $error("Edge lost during clearing write.");

	a_core_request: assert property (
		ie_reg && summary && !wr_flags && !wr_ctrl |=> core_irq_req)
		else $error("Core request missing.");

	a_irq_line: assert property (
		|(status_reg & mask_reg) && !wr_status && !wr_mask |=> irq)
		else $error("Interrupt line low with pending event.");

endmodule

// [verification/pcd_port_model.sv]
// Partner model of the monitored port pins and the sleeping core.
`timescale 1ns/100ps
module pcd_port_model (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       rst,
	// Commands from the bench.
	input  wire logic [5:0] pin_level,
	input  wire logic       sleep_cmd,
	// Device side.
	input  wire logic       core_wake_req,
	output logic      [5:0] port_a_pin,
	output logic            core_sleep
);
	// =========================================================
	// Pins change just after the clock edge.
	always_ff @(posedge clock) begin
		port_a_pin <= pin_level;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			core_sleep <= 1'b0;
		end else if (core_wake_req) begin
			core_sleep <= 1'b0;
		end else if (sleep_cmd) begin
			core_sleep <= 1'b1;
		end
	end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the pin change detector.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
	// =========================================================
	// Stimulus and observation.
	logic        clock     = 1'b0;
	logic        rst       = 1'b1;
	logic        hsel      = 1'b0;
	logic [31:0] haddr     = 32'h0000_0000;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [31:0] hwdata    = 32'h0000_0000;
	logic [5:0]  pin_level = 6'h00;
	logic        sleep_cmd = 1'b0;
	logic        hreadyout, hresp, core_irq_req, core_wake_req;
	logic        global_irq_enable, irq, core_sleep;
	logic [31:0] hrdata, rd;
	logic [5:0]  port_a_pin;
	logic [47:0] row;
	int          errors    = 0;
	int          checked   = 0;
	int          cycles    = 0;
	// Rise enable, fall enable, pins from, pins to, control, flags.
	logic [47:0] rows [5] = '{48'h3F00_003F_083F, 48'h003F_003F_0800,
		48'h0015_3F00_0015, 48'h2A15_0F30_0825, 48'h0000_003F_0000};

	always #5 clock = ~clock;

	pcd_top u_pcd_top (.clock(clock), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .port_a_pin(port_a_pin),
		.core_sleep(core_sleep), .core_irq_req(core_irq_req),
		.core_wake_req(core_wake_req),
		.global_irq_enable(global_irq_enable), .irq(irq));

	pcd_port_model u_pcd_port_model (.clock(clock), .rst(rst),
		.pin_level(pin_level), .sleep_cmd(sleep_cmd),
		.core_wake_req(core_wake_req), .port_a_pin(port_a_pin),
		.core_sleep(core_sleep));

	// =========================================================
	// One single AHB-Lite transfer; read data lands in rd.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	// =========================================================
	// Main sequence.
	initial begin
		tick(16);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 8'(i * 4), 32'h0);
			`CHK("reset value", 32'h0000_0000, rd)
			`CHK("okay response", 1'b0, hresp)
		end
		foreach (rows[i]) begin
			row = rows[i];
			bus(1'b1, 8'h00, {24'h0, row[47:40]});
			bus(1'b1, 8'h04, {24'h0, row[39:32]});
			bus(1'b1, 8'h0C, {24'h0, row[15:8]});
			pin_level <= row[29:24];
			tick(6);
			bus(1'b1, 8'h08, 32'h0);
			pin_level <= row[21:16];
			tick(6);
			bus(1'b0, 8'h08, 32'h0);
			`CHK("flags", {24'h0, row[7:0]}, rd)
			bus(1'b0, 8'h0C, 32'h0);
			`CHK("ctrl", {24'h0, row[15:8] | 8'(row[7:0] != 0)}, rd)
			`CHK("core req", row[11] & (row[7:0] != 0), core_irq_req)
		end
		bus(1'b1, 8'h00, 32'h0000_00FF);
		bus(1'b0, 8'h00, 32'h0);
		`CHK("rise reserved", 32'h0000_003F, rd)
		bus(1'b1, 8'h0C, 32'h0000_00FF);
		bus(1'b0, 8'h0C, 32'h0);
		`CHK("ctrl bits", 32'h0000_0088, rd)
		`CHK("global enable", 1'b1, global_irq_enable)
		bus(1'b1, 8'h40, 32'h0000_00FF);
		bus(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0000_0000, rd)
		bus(1'b1, 8'h04, 32'h0000_003F);
		bus(1'b1, 8'h14, 32'h0000_0000);
		bus(1'b1, 8'h10, 32'h0000_003F);
		pin_level <= 6'h00;
		tick(6);
		bus(1'b0, 8'h10, 32'h0);
		`CHK("status", 32'h0000_003F, rd)
		`CHK("irq masked", 1'b0, irq)
		bus(1'b1, 8'h14, 32'h0000_0001);
		tick(2);
		`CHK("irq unmasked", 1'b1, irq)
		bus(1'b1, 8'h10, 32'h0000_003F);
		tick(2);
		`CHK("irq cleared", 1'b0, irq)
		// An enabled edge lands on the edge that commits a clearing write.
		pin_level <= 6'h01;
		@(posedge clock);
		bus(1'b1, 8'h08, 32'h0);
		bus(1'b0, 8'h08, 32'h0);
		`CHK("clear race", 32'h0000_0001, rd)
		// Software clears only the bits it has seen set.
		bus(1'b0, 8'h08, 32'h0);
		bus(1'b1, 8'h08, rd ^ 32'h0000_00FF);
		bus(1'b0, 8'h08, 32'h0);
		`CHK("flags cleared", 32'h0000_0000, rd)
		bus(1'b1, 8'h08, 32'h0000_003F);
		bus(1'b0, 8'h08, 32'h0);
		`CHK("write cannot set", 32'h0000_0000, rd)
		`CHK("core req low", 1'b0, core_irq_req)
		@(posedge clock);
		sleep_cmd <= 1'b1;
		@(posedge clock);
		sleep_cmd <= 1'b0;
		tick(2);
		pin_level <= 6'h3F;
		for (int i = 0; i < 20 && core_sleep !== 1'b0; i++) begin
			@(posedge clock);
		end
		`CHK("woken", 1'b0, core_sleep)
		bus(1'b0, 8'h08, 32'h0);
		`CHK("flags after wake", 32'h0000_003E, rd)
		@(posedge clock);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		bus(1'b0, 8'h08, 32'h0);
		`CHK("flags after reset", 32'h0000_0000, rd)
		bus(1'b0, 8'h00, 32'h0);
		`CHK("rise after reset", 32'h0000_0000, rd)
		tally_and_finish();
	end
endmodule
